// *** common/irs_consts.svh ***
// Purpose: Constants for the integrator reset sequencer
// Assumes: 50 MHz sys_clk, 20 ns period
// Notes: Times in ns, cycle counts derived from them
`ifndef IRS_CONSTS_SVH
`define IRS_CONSTS_SVH
`define IRS_CLK_PERIOD_NS 20
`define IRS_NS_PER_KOHM 10
`define IRS_MIN_HOLD_NS 150
`define IRS_MIN_HOLD_CYC ((`IRS_MIN_HOLD_NS + `IRS_CLK_PERIOD_NS - 1) / `IRS_CLK_PERIOD_NS)
`define IRS_CAL_TIME_NS 100000
`define IRS_CAL_CYC (`IRS_CAL_TIME_NS / `IRS_CLK_PERIOD_NS)
`define IRS_WD_TIME_NS 200000
`define IRS_WD_CYC (`IRS_WD_TIME_NS / `IRS_CLK_PERIOD_NS)
`define IRS_CNT_W 24
`define IRS_KOHM_W 12
`define IRS_MIN_KOHM 12'h010
`define IRS_OUT_W 8
`define IRS_OUT_MIN 8'h00
`define IRS_MODE_W 2
`endif

// *** common/irs_pkg.sv ***
// Purpose: Types for the integrator reset sequencer
// Assumes: Constants come from irs_consts.svh
// Notes: Gray codes along lockout, calibrate, armed, reset, measure
`default_nettype none
package irs_pkg;
   typedef enum logic [2:0] {
      IRS_LOCKOUT = 3'h0,
      IRS_CALIB = 3'h1,
      IRS_ARMED = 3'h3,
      IRS_RESET = 3'h2,
      IRS_MEASURE = 3'h6
   } irs_state_e;
   typedef enum logic [1:0] {
      IRS_SINGLE = 2'h0,
      IRS_PING2 = 2'h1,
      IRS_PING4 = 2'h2
   } irs_mode_e;
endpackage
`default_nettype wire

// *** rtl/irs_oneshot.sv ***
// Purpose: Programmable one-shot holding the integrator in reset
// Assumes: duration_resistor_kohm is stable while armed
// Notes: 10 ns per kilohm, rounded up to whole cycles
`default_nettype none
`include "irs_consts.svh"
module irs_oneshot (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic trigger,
   input wire logic [`IRS_KOHM_W-1:0] duration_resistor_kohm,
   output logic busy
);
   logic [`IRS_CNT_W-1:0] count_r;
   logic [`IRS_CNT_W-1:0] load_val;

   // Hold time in cycles; clamps settings below the usable floor
   always_comb begin
      load_val = `IRS_CNT_W'((32'(duration_resistor_kohm) * `IRS_NS_PER_KOHM + `IRS_CLK_PERIOD_NS - 1)
                 / `IRS_CLK_PERIOD_NS);
      if (duration_resistor_kohm < `IRS_MIN_KOHM) begin
         load_val = `IRS_CNT_W'(`IRS_MIN_HOLD_CYC);
      end
   end

   // Down counter; a trigger while idle starts it, retrigger ignored
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count_r <= '0;
      end else if (trigger && count_r == '0) begin
         count_r <= load_val;
      end else if (count_r != '0) begin
         count_r <= count_r - `IRS_CNT_W'(1);
      end
   end

   assign busy = (count_r != '0);
endmodule
`default_nettype wire

// *** rtl/irs_sequencer.sv ***
// Purpose: Lockout, calibration, reset and measure sequencing
// Assumes: Gate timing inputs synchronous to sys_clk
// Notes: Output values stand in for the analog waveform
`default_nettype none
`include "irs_consts.svh"
module irs_sequencer #(
   parameter int unsigned CAL_CYCLES = `IRS_CAL_CYC,
   parameter int unsigned WD_CYCLES = `IRS_WD_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic supply_lockout,
   input wire logic supply_above_hyst,
   input wire logic [1:0] output_mode,
   input wire logic timer_mode,
   input wire logic [`IRS_KOHM_W-1:0] duration_resistor_kohm,
   input wire logic gate_timing_in_a,
   input wire logic gate_timing_in_b,
   input wire logic gate_timing_in_c,
   input wire logic gate_timing_in_d,
   input wire logic forward_current,
   input wire logic [`IRS_OUT_W-1:0] sense_level,
   output logic [`IRS_OUT_W-1:0] sense_out_first,
   output logic [`IRS_OUT_W-1:0] sense_out_second,
   output logic integrator_reset,
   output logic fault_out,
   output logic fault_oe,
   output logic [2:0] seq_state
);
   // ************************************************************
   // Declarations
   // ************************************************************
   irs_pkg::irs_state_e state_r;
   irs_pkg::irs_state_e state_nxt;
   logic [`IRS_CNT_W-1:0] cal_cnt_r;
   logic [`IRS_CNT_W-1:0] wd_cnt_r;
   logic fault_r;
   logic [`IRS_OUT_W-1:0] out_first_r;
   logic [`IRS_OUT_W-1:0] out_second_r;
   logic rst_cond;
   logic rst_cond_d_r;
   logic shot_busy;
   logic hold_reset;
   logic route_first;
   logic route_second;
   logic cal_done;
   logic wd_expired;

   // ************************************************************
   // Reset condition and routing
   // ************************************************************

   // Reset logic per output mode
   function automatic logic reset_logic(input logic [1:0] m, input logic a, input logic b,
                                        input logic c, input logic d);
      case (m)
         irs_pkg::IRS_PING2: reset_logic = !a && !b;
         irs_pkg::IRS_PING4: reset_logic = !(a && !b) && !(c && !d);
         default: reset_logic = a ^ b;
      endcase
   endfunction

   always_comb begin
      rst_cond = reset_logic(output_mode, gate_timing_in_a, gate_timing_in_b,
                             gate_timing_in_c, gate_timing_in_d);
   end

   // Output steering by mode
   always_comb begin
      route_first = 1'b1;
      route_second = 1'b0;
      if (output_mode == irs_pkg::IRS_PING2) begin
         route_first = gate_timing_in_a;
         route_second = gate_timing_in_b;
      end else if (output_mode == irs_pkg::IRS_PING4) begin
         route_first = gate_timing_in_c && !gate_timing_in_d;
         route_second = gate_timing_in_a && !gate_timing_in_b;
      end
   end

   // ************************************************************
   // Integrator reset hold
   // ************************************************************

   // Edge of the condition fires the one-shot; level would retrigger forever
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_cond_d_r <= 1'b0;
      end else begin
         rst_cond_d_r <= rst_cond;
      end
   end

   irs_oneshot u_oneshot (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .trigger(timer_mode && rst_cond && !rst_cond_d_r &&
               (state_r == irs_pkg::IRS_ARMED || state_r == irs_pkg::IRS_MEASURE)),
      .duration_resistor_kohm(duration_resistor_kohm),
      .busy(shot_busy)
   );

   // Level mode holds as long as the condition; timer mode as long as the shot
   always_comb begin
      if (timer_mode) begin
         hold_reset = shot_busy || (rst_cond && !rst_cond_d_r);
      end else begin
         hold_reset = rst_cond;
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   assign cal_done = (cal_cnt_r >= `IRS_CNT_W'(CAL_CYCLES - 1));
   assign wd_expired = (wd_cnt_r >= `IRS_CNT_W'(WD_CYCLES - 1));

   // Next state; lockout overrides everything
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         irs_pkg::IRS_LOCKOUT: begin
            if (!supply_lockout && supply_above_hyst) begin
               state_nxt = irs_pkg::IRS_CALIB;
            end
         end
         irs_pkg::IRS_CALIB: begin
            if (cal_done) begin
               state_nxt = irs_pkg::IRS_ARMED;
            end
         end
         irs_pkg::IRS_ARMED: begin
            if (hold_reset) begin
               state_nxt = irs_pkg::IRS_RESET;
            end
         end
         irs_pkg::IRS_RESET: begin
            if (!hold_reset) begin
               state_nxt = irs_pkg::IRS_MEASURE;
            end
         end
         irs_pkg::IRS_MEASURE: begin
            if (hold_reset) begin
               state_nxt = irs_pkg::IRS_RESET;
            end
         end
         default: state_nxt = irs_pkg::IRS_LOCKOUT;
      endcase
      if (supply_lockout) begin
         state_nxt = irs_pkg::IRS_LOCKOUT;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= irs_pkg::IRS_LOCKOUT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Calibration timer
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cal_cnt_r <= '0;
      end else if (state_r != irs_pkg::IRS_CALIB) begin
         cal_cnt_r <= '0;
      end else if (!cal_done) begin
         cal_cnt_r <= cal_cnt_r + `IRS_CNT_W'(1);
      end
   end

   // Watchdog on measure length; saturates so it never wraps
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wd_cnt_r <= '0;
      end else if (state_r != irs_pkg::IRS_MEASURE) begin
         wd_cnt_r <= '0;
      end else if (!wd_expired) begin
         wd_cnt_r <= wd_cnt_r + `IRS_CNT_W'(1);
      end
   end

   // Fault sticks until the next reset cycle or lockout
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fault_r <= 1'b0;
      end else if (state_r == irs_pkg::IRS_MEASURE && wd_expired) begin
         fault_r <= 1'b1;
      end else if (state_r == irs_pkg::IRS_RESET || state_r == irs_pkg::IRS_LOCKOUT) begin
         fault_r <= 1'b0;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   // Outputs at minimum except while measuring forward current
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         out_first_r <= `IRS_OUT_MIN;
         out_second_r <= `IRS_OUT_MIN;
      end else begin
         out_first_r <= `IRS_OUT_MIN;
         out_second_r <= `IRS_OUT_MIN;
         if (state_r == irs_pkg::IRS_MEASURE && forward_current) begin
            if (route_first) begin
               out_first_r <= sense_level;
            end
            if (route_second) begin
               out_second_r <= sense_level;
            end
         end
      end
   end

   assign sense_out_first = out_first_r;
   assign sense_out_second = out_second_r;
   assign integrator_reset = (state_r != irs_pkg::IRS_MEASURE); // Integrator zeroed outside measure
   assign fault_out = 1'b0; // Open drain: only ever pulls low
   assign fault_oe = !fault_r; // Enable low while driving
   assign seq_state = state_r;
endmodule
`default_nettype wire

// *** testbench/irs_checker.sv ***
// Purpose: Port assertions for the sequencer
// Assumes: One clock, async active-low reset
// Notes: Watchdog check allows two cycles for the registered flag
`default_nettype none
module irs_checker #(
   parameter int unsigned CAL_CYCLES = 8,
   parameter int unsigned WD_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic supply_lockout,
   input wire logic supply_above_hyst,
   input wire logic [1:0] output_mode,
   input wire logic timer_mode,
   input wire logic [11:0] duration_resistor_kohm,
   input wire logic gate_timing_in_a,
   input wire logic gate_timing_in_b,
   input wire logic gate_timing_in_c,
   input wire logic gate_timing_in_d,
   input wire logic forward_current,
   input wire logic [7:0] sense_level,
   input wire logic [7:0] sense_out_first,
   input wire logic [7:0] sense_out_second,
   input wire logic integrator_reset,
   input wire logic fault_out,
   input wire logic fault_oe,
   input wire logic [2:0] seq_state
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] meas_cnt;
   wire logic xr = gate_timing_in_a ^ gate_timing_in_b;
   wire logic lvl1 = !timer_mode && output_mode == 2'h0 && !supply_lockout;
   // Consecutive measure cycles, saturating so a long run cannot wrap
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) meas_cnt <= 8'h00;
      else if (seq_state != 3'h6) meas_cnt <= 8'h00;
      else if (meas_cnt != 8'hff) meas_cnt <= meas_cnt + 8'h01;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_hold_go;
      $rose(seq_state == 3'h2) && timer_mode && duration_resistor_kohm < 12'h010 && !supply_lockout;
   endsequence
   sequence s_hold_run;
      (seq_state == 3'h2)[*8];
   endsequence
   lock_in_a: assert property (supply_lockout |=> seq_state == 3'h0) else $error("no lockout");
   lock_exit_a: assert property (seq_state == 3'h0 && !supply_lockout && supply_above_hyst
      |=> seq_state == 3'h1) else $error("no calibration");
   out_min_a: assert property (seq_state != 3'h6 || !forward_current
      |=> sense_out_first == 8'h00 && sense_out_second == 8'h00) else $error("output not minimum");
   lvl_enter_a: assert property (lvl1 && seq_state[0] == seq_state[1] && seq_state != 3'h0 && xr
      |=> seq_state == 3'h2) else $error("no level reset");
   lvl_leave_a: assert property (lvl1 && seq_state == 3'h2 && !xr
      |=> seq_state == 3'h6) else $error("no measure");
   timer_hold_a: assert property (s_hold_go |-> s_hold_run) else $error("hold too short");
   wd_fault_a: assert property (seq_state == 3'h6 && meas_cnt > WD_CYCLES + 1
      |-> !fault_oe) else $error("no fault");
   fault_pin_a: assert property (fault_out == 1'b0) else $error("fault pin driven high");
endmodule
bind irs_sequencer irs_checker #(.CAL_CYCLES(CAL_CYCLES), .WD_CYCLES(WD_CYCLES)) u_chk (.*);
`default_nettype wire

// *** testbench/irs_gate_ctrl.sv ***
// Purpose: Switching controller model on the gate timing inputs
// Assumes: Patterns are requested just after a rising edge
// Notes: Forward current is withheld while a reset pattern shows
`default_nettype none
module irs_gate_ctrl (
   input wire logic sys_clk,
   input wire logic [1:0] mode,
   input wire logic [3:0] pat,
   input wire logic fwd_req,
   output logic [3:0] gate,
   output logic fwd,
   output logic cond
);
   timeunit 1ns;
   timeprecision 1ns;
   logic fwd_r;
   initial {gate, fwd_r} = 5'h00;
   // Reset pattern as seen on the controller's own pins
   always_comb begin
      case (mode)
         2'h1: cond = !(gate[3] | gate[2]);
         2'h2: cond = !((gate[3] & !gate[2]) | (gate[1] & !gate[0]));
         default: cond = gate[3] ^ gate[2];
      endcase
   end
   assign fwd = fwd_r & !cond;
   // Pins move only on the clock, like a real gate driver
   always @(posedge sys_clk) begin
      gate <= pat;
      fwd_r <= fwd_req;
   end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the integrator reset sequencer
// Assumes: Calibration 8 and watchdog 20 cycles
// Notes: Timer mode is judged by hold length, not the cycle model
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned CAL = 8;
   logic sys_clk, resetn, supply_lockout, supply_above_hyst, timer_mode, fwd_req, model_on, cond;
   wire logic gate_timing_in_a, gate_timing_in_b, gate_timing_in_c, gate_timing_in_d, forward_current;
   logic integrator_reset, fault_out, fault_oe;
   logic [1:0] output_mode;
   logic [2:0] seq_state, m_state;
   logic [3:0] pat, p;
   logic [7:0] sense_level, sense_out_first, sense_out_second, m_first, m_second;
   logic [11:0] duration_resistor_kohm;
   int num_errors = 0;
   int checks = 0;
   int m_cnt, cnt, h;
   irs_sequencer #(.CAL_CYCLES(CAL), .WD_CYCLES(20)) DUT (.*);
   irs_gate_ctrl u_ctrl (.sys_clk(sys_clk), .mode(output_mode), .pat(pat), .fwd_req(fwd_req), .gate({gate_timing_in_a,
      gate_timing_in_b, gate_timing_in_c, gate_timing_in_d}), .fwd(forward_current), .cond(cond));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic drive(input logic [3:0] pv, input logic fv, input int n);
      @(posedge sys_clk);
      pat <= pv;
      fwd_req <= fv;
      repeat (n) @(posedge sys_clk);
   endtask
   // Random legal patterns; overlapping routes are left out
   task automatic rand_run(input int n);
      repeat (n) begin
         p = 4'($urandom);
         if (output_mode == 2'h1) p = {p[3], p[2] & !p[3], 2'h0};
         if (output_mode == 2'h2 && p[3] && !p[2]) p[1] = 1'b0;
         drive(p, 1'($urandom), 0);
      end
   endtask
   always @(posedge sys_clk) sense_level <= 8'($urandom);
   // Cycle model of level-mode sequencing and routing
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         {m_state, m_first, m_second} = 19'h00000;
      end else begin
         m_first = (m_state == 3'h6 && forward_current === 1'b1 && (output_mode == 2'h1 ? gate_timing_in_a :
            output_mode == 2'h2 ? gate_timing_in_c & !gate_timing_in_d : 1'b1)) ? sense_level : 8'h00;
         m_second = (m_state == 3'h6 && forward_current === 1'b1 && (output_mode == 2'h1 ? gate_timing_in_b :
            output_mode == 2'h2 && gate_timing_in_a & !gate_timing_in_b)) ? sense_level : 8'h00;
         case (m_state)
            3'h0: begin
               m_cnt = 0;
               if (supply_above_hyst) m_state = 3'h1;
            end
            3'h1: begin
               m_cnt++;
               if (m_cnt == CAL) m_state = 3'h3;
            end
            3'h2: if (!cond) m_state = 3'h6;
            default: if (cond) m_state = 3'h2;
         endcase
         if (supply_lockout) m_state = 3'h0;
      end
   end
   // Compare on the falling edge, once registered outputs have settled
   always @(negedge sys_clk) begin
      if (model_on && resetn) begin
         check(seq_state, m_state);
         check(sense_out_first, m_first);
         check(sense_out_second, m_second);
         check(integrator_reset, 8'(m_state != 3'h6));
      end
   end
   initial begin
      {resetn, supply_lockout, supply_above_hyst, timer_mode, fwd_req, model_on} = 6'h11;
      {output_mode, pat, sense_level, duration_resistor_kohm} = 26'h0000028;
      void'($urandom(96));
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      rand_run(6);
      supply_lockout <= 1'b0;
      rand_run(4);
      supply_above_hyst <= 1'b1;
      rand_run(12);
      for (int m = 0; m < 4; m++) begin
         output_mode <= 2'(m);
         @(posedge sys_clk);
         rand_run(60);
      end
      output_mode <= 2'h0;
      drive(4'h0, 1'b1, 30);
      @(negedge sys_clk);
      check(fault_oe, 8'h00);
      check(fault_out, 8'h00);
      drive(4'h8, 1'b0, 3);
      @(negedge sys_clk);
      check(fault_oe, 8'h01);
      drive(4'h0, 1'b1, 3);
      model_on <= 1'b0;
      timer_mode <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         duration_resistor_kohm <= i ? 12'h008 : 12'h028;
         drive(4'h0, 1'b1, 4);
         drive(4'h8, 1'b0, 0);
         cnt = 0;
         repeat (60) @(negedge sys_clk) cnt += int'(integrator_reset === 1'b1);
         h = i ? (150 + 19) / 20 : 40 * 10 / 20;
         check(8'(cnt == h || cnt == h + 1), 8'h01);
      end
      @(posedge sys_clk);
      supply_lockout <= 1'b1;
      timer_mode <= 1'b0;
      drive(4'h0, 1'b0, 2);
      model_on <= 1'b1;
      supply_lockout <= 1'b0;
      drive(4'h0, 1'b0, 14);
      resetn <= 1'b0;
      drive(4'h0, 1'b0, 2);
      resetn <= 1'b1;
      rand_run(20);
      give_verdict();
   end
   // Hang guard, well past the expected run of some 500 cycles
   initial begin
      #50000;
      num_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
